// ===== rtl/brt_rx_regs.svh
// Constants for the single-wire brightness command receiver.
// Assumes a 200 MHz aclk; included by bare name.
// What this block does
// - A frame is 24 bits: 16-bit data then 8-bit address.
// - Address sits in frame bits 23 down to 16, so it arrives last.
// - Brightness code is frame bits 8 down to 0, bit 8 most significant.
// - Bit 10 requests acknowledge; good frame then pulls the line low.
// - Malformed or incomplete frames never get an acknowledge pulse.
// - Self-timed decoder accepts any rate from 1.7 to 160 kbit/s.
// - Falling edge to falling edge; low twice high is 0, high twice low is 1.
// - After a validation delay the acknowledge low lasts at most 512 us.
// - Brightness powers up all ones and returns there when disabled.
`ifndef BRT_RX_REGS_SVH
`define BRT_RX_REGS_SVH

// ****************************************
// Frame layout
// ****************************************
`define FRAME_BITS 24
`define DEV_ADDR 8'h8F
`define ADDR_TOP 23
`define ADDR_BOT 16
`define ACK_REQ_BIT 10
`define BRT_TOP 8
`define BRT_DEFAULT 9'h1FF

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 200
`define MIN_BIT_RATE_HZ 1700
`define BIT_TIMEOUT_CYC ((`CLK_MHZ * 1000000) / `MIN_BIT_RATE_HZ)
`define ACK_LOW_TIME_US 512
`define ACK_LOW_CYC (`ACK_LOW_TIME_US * `CLK_MHZ)
`define ACK_DELAY_NS 1000
`define ACK_DELAY_CYC ((`ACK_DELAY_NS * `CLK_MHZ + 999) / 1000)

// ****************************************
// Register map
// ****************************************
`define REG_CTRL 8'h00
`define REG_BRIGHT 8'h04
`define REG_STATUS 8'h08
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'b1
`define ST_GOOD_BIT 0
`define ST_BAD_BIT 1
`define ST_MISS_BIT 2
`define ST_ACK_BIT 3
`define ST_CNT_LSB 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/brt_rx_pkg.sv
// Types for the single-wire brightness command receiver.
// Assumes nothing beyond the constants header.
package brt_rx_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LOW   = 5'b00010,
        ST_HIGH  = 5'b00100,
        ST_VALID = 5'b01000,
        ST_ACK   = 5'b10000
    } rx_state_type;

endpackage

// ===== rtl/pin_sync.sv
// Three-stage synchroniser for an asynchronous pin.
// Assumes aclk and synchronous active-low aresetn.
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and filtered level
    input wire logic pin,
    output logic level
);

    logic ff1_r;
    logic ff2_r;
    logic ff3_r;

    // ****************************************
    // Chain and agreement filter
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ff1_r <= RESET_LEVEL;
            ff2_r <= RESET_LEVEL;
            ff3_r <= RESET_LEVEL;
        end else begin
            ff1_r <= pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= RESET_LEVEL;
        end else if (ff2_r == ff3_r) begin
            level <= ff3_r;
        end
    end

endmodule

// ===== rtl/one_wire_brightness_cmd_rx.sv
// Single-wire brightness command receiver with AXI4-Lite registers.
// Assumes an open-drain line with external pull-up and a 200 MHz aclk.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "brt_rx_regs.svh"
module one_wire_brightness_cmd_rx import brt_rx_pkg::*; #(
    parameter logic [17:0] BIT_TIMEOUT = 18'(`BIT_TIMEOUT_CYC),
    parameter logic [17:0] ACK_LOW = 18'(`ACK_LOW_CYC),
    parameter logic [17:0] ACK_DELAY = 18'(`ACK_DELAY_CYC)
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Command line
    input wire logic line_in,
    output logic line_out,
    output logic line_oe_n,
    // Brightness result
    output logic [8:0] brightness_code,
    output logic ack_active
);

    rx_state_type state_r;
    logic line_lvl;
    logic prev_r;
    logic [17:0] cnt_r;
    logic [17:0] low_len_r;
    logic [4:0] nbits_r;
    logic bad_r;
    logic [23:0] sr_r;
    logic ctrl_en_r;
    logic [2:0] stat_r;
    logic [7:0] good_cnt_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic rise;
    logic fall;
    logic bit_one;
    logic bit_zero;
    logic bit_bad;
    logic addr_ok;
    logic frame_end;
    logic frame_ok;
    logic abort_evt;
    logic wr_fire;
    logic [2:0] stat_set;
    logic [2:0] stat_clr;

    // ****************************************
    // Line sampling and bit decode
    // ****************************************
    pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(line_in),
        .level(line_lvl)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= line_lvl;
        end
    end

    assign rise = line_lvl & ~prev_r;
    assign fall = ~line_lvl & prev_r;
    assign bit_one = {1'b0, cnt_r} >= {low_len_r, 1'b0};
    assign bit_zero = {1'b0, low_len_r} >= {cnt_r, 1'b0};
    assign bit_bad = ~bit_one & ~bit_zero;
    assign addr_ok = sr_r[`ADDR_TOP:`ADDR_BOT] == `DEV_ADDR;
    assign frame_end = (state_r == ST_VALID) && (cnt_r == ACK_DELAY - 18'h0_0001);
    assign frame_ok = ~bad_r & addr_ok;
    assign abort_evt = ((state_r == ST_LOW) || (state_r == ST_HIGH)) && (cnt_r >= BIT_TIMEOUT) && (nbits_r != 5'h00);

    // ****************************************
    // Receive sequencer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_en_r) begin
            state_r <= ST_IDLE;
            cnt_r <= 18'h0_0000;
            low_len_r <= 18'h0_0000;
            nbits_r <= 5'h00;
            bad_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 18'h0_0000;
                    nbits_r <= 5'h00;
                    bad_r <= 1'b0;
                    if (fall) begin
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    cnt_r <= cnt_r + 18'h0_0001;
                    if (rise) begin
                        low_len_r <= cnt_r;
                        cnt_r <= 18'h0_0000;
                        state_r <= ST_HIGH;
                    end else if (cnt_r >= BIT_TIMEOUT) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_HIGH: begin
                    cnt_r <= cnt_r + 18'h0_0001;
                    if (fall) begin
                        cnt_r <= 18'h0_0000;
                        nbits_r <= nbits_r + 5'h01;
                        bad_r <= bad_r | bit_bad;
                        if (nbits_r == 5'(`FRAME_BITS - 1)) begin
                            state_r <= ST_VALID;
                        end else begin
                            state_r <= ST_LOW;
                        end
                    end else if (cnt_r >= BIT_TIMEOUT) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_VALID: begin
                    cnt_r <= cnt_r + 18'h0_0001;
                    if (frame_end) begin
                        cnt_r <= 18'h0_0000;
                        if (frame_ok && sr_r[`ACK_REQ_BIT]) begin
                            state_r <= ST_ACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    cnt_r <= cnt_r + 18'h0_0001;
                    if (cnt_r == ACK_LOW - 18'h0_0001) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Shift in least significant bit first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_r <= 24'h00_0000;
        end else if (state_r == ST_HIGH && fall) begin
            sr_r <= {bit_one, sr_r[23:1]};
        end
    end

    // ****************************************
    // Brightness and acknowledge
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_en_r) begin
            brightness_code <= `BRT_DEFAULT;
        end else if (frame_end && frame_ok) begin
            brightness_code <= sr_r[`BRT_TOP:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_oe_n <= 1'b1;
        end else begin
            line_oe_n <= ~(ctrl_en_r && frame_end && frame_ok && sr_r[`ACK_REQ_BIT])
                         & ~(state_r == ST_ACK && cnt_r != ACK_LOW - 18'h0_0001 && ctrl_en_r);
        end
    end

    assign line_out = 1'b0;
    assign ack_active = ~line_oe_n;

    // ****************************************
    // Status
    // ****************************************
    assign stat_set = {frame_end & ~bad_r & ~addr_ok, abort_evt | (frame_end & bad_r), frame_end & frame_ok};
    assign stat_clr = (wr_fire && awaddr_r == `REG_STATUS && wstrb_r[0]) ? wdata_r[2:0] : 3'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 3'h0;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            good_cnt_r <= 8'h00;
        end else if (frame_end && frame_ok) begin
            good_cnt_r <= good_cnt_r + 8'h01;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign awready = ~aw_hold_r & ~bvalid;
    assign wready = ~w_hold_r & ~bvalid;
    assign arready = ~rvalid;
    assign wr_fire = aw_hold_r & w_hold_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= awaddr;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (awaddr_r == `REG_CTRL || awaddr_r == `REG_BRIGHT || awaddr_r == `REG_STATUS) ?
                     `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_r <= `CTRL_RESET;
        end else if (wr_fire && awaddr_r == `REG_CTRL && wstrb_r[0]) begin
            ctrl_en_r <= wdata_r[`CTRL_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (araddr)
                `REG_CTRL: rdata <= {31'h0000_0000, ctrl_en_r};
                `REG_BRIGHT: rdata <= {23'h00_0000, brightness_code};
                `REG_STATUS: rdata <= {16'h0000, good_cnt_r, 4'h0, ack_active, stat_r};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [17:0] drive_len_r;

    always_ff @(posedge aclk) begin
        if (!aresetn || line_oe_n) begin
            drive_len_r <= 18'h0_0000;
        end else begin
            drive_len_r <= drive_len_r + 18'h0_0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    frame_length_a: assert property ((state_r == ST_HIGH) && fall && (nbits_r == 5'h17) && ctrl_en_r |=> state_r == ST_VALID)
        else $error("frame not closed after 24 bits");
    short_frame_a: assert property ((state_r == ST_HIGH) && fall && (nbits_r < 5'h17) && ctrl_en_r |=> state_r == ST_LOW)
        else $error("frame closed early");
    addr_reject_a: assert property (frame_end && !addr_ok && ctrl_en_r |=> $stable(brightness_code))
        else $error("mismatched address changed brightness");
    lsb_first_a: assert property ((state_r == ST_HIGH) && fall && ctrl_en_r |=> sr_r[23] == $past(bit_one))
        else $error("bit not shifted in at top");
    code_load_a: assert property (frame_end && frame_ok && ctrl_en_r |=> brightness_code == $past(sr_r[8:0]))
        else $error("brightness not loaded");
    ack_drive_a: assert property (frame_end && frame_ok && sr_r[10] && ctrl_en_r |=> !line_oe_n [*8])
        else $error("acknowledge not driven");
    no_bad_ack_a: assert property (frame_end && bad_r |=> line_oe_n [*8])
        else $error("acknowledge on malformed frame");
    ratio_check_a: assert property ((state_r == ST_HIGH) && fall && bit_bad && ctrl_en_r |=> bad_r)
        else $error("ambiguous bit not flagged");
    bit_timeout_a: assert property ((state_r == ST_LOW || state_r == ST_HIGH) |-> cnt_r <= BIT_TIMEOUT)
        else $error("bit timer ran past timeout");
    ack_length_a: assert property (drive_len_r <= ACK_LOW)
        else $error("acknowledge held too long");
    default_code_a: assert property (!ctrl_en_r |=> brightness_code == `BRT_DEFAULT)
        else $error("brightness not default when disabled");

    good_ack_c: cover property (frame_end && frame_ok && sr_r[10]);
    addr_miss_c: cover property (frame_end && !addr_ok);
    bad_frame_c: cover property (frame_end && bad_r);
    abort_c: cover property (abort_evt);

endmodule

// ===== sim/cmd_line_master.sv
// Partner model: command master driving the single-wire line.
// Assumes an open-drain drive; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module cmd_line_master #(
    parameter int START_CYC = 400,
    parameter int EOS_CYC = 400
) (
    // Clock
    input wire logic aclk,
    // Open-drain drive, high pulls the line low
    output logic pull_low
);
    initial begin
        pull_low = 1'b0;
    end
    // ****************************************
    // Frame sender
    // ****************************************
    task automatic send(input logic [23:0] frame, input int nbits, input int t_s, input int t_l, input int bad);
        int lo;
        int hi;
        pull_low <= 1'b0;
        repeat (START_CYC) @(posedge aclk);
        for (int i = 0; i < nbits; i++) begin
            lo = frame[i] ? t_s : t_l;
            hi = frame[i] ? t_l : t_s;
            if (i == bad) begin
                hi = lo;
            end
            pull_low <= 1'b1;
            repeat (lo) @(posedge aclk);
            pull_low <= 1'b0;
            repeat (hi) @(posedge aclk);
        end
        if (nbits == 24) begin
            pull_low <= 1'b1;
            repeat (EOS_CYC) @(posedge aclk);
            pull_low <= 1'b0;
        end
    endtask
endmodule

// ===== sim/one_wire_brightness_cmd_rx_bench.sv
// Self-checking bench for the single-wire brightness receiver.
// Assumes the constants header and a pulled-up open-drain line.
`timescale 1ns/1ps
`include "brt_rx_regs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module one_wire_brightness_cmd_rx_bench;
    localparam int ACK_LOW_C = 50;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, line_out, line_oe_n, ack_active, pull_low;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [8:0] brightness_code;
    wire logic line = !(pull_low || !line_oe_n);
    int error_cnt = 0;
    int total_checks = 0;
    int ack_cnt = 0;
    int ack_run = 0;
    int ack_len = 0;

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    one_wire_brightness_cmd_rx #(.BIT_TIMEOUT(18'h07D0), .ACK_LOW(18'h0032), .ACK_DELAY(18'h01F4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_in(line), .line_out(line_out),
        .line_oe_n(line_oe_n), .brightness_code(brightness_code), .ack_active(ack_active));

    cmd_line_master u_master (.aclk(aclk), .pull_low(pull_low));

    // ****************************************
    // Acknowledge seen on the wire
    // ****************************************
    always @(posedge aclk) begin
        if (line === 1'b0 && !pull_low) begin
            ack_run <= ack_run + 1;
        end else if (ack_run != 0) begin
            ack_len <= ack_run;
            ack_cnt <= ack_cnt + 1;
            ack_run <= 0;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (200) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                got = 1'b1;
                break;
            end
        end
        bready <= 1'b0;
        if (!got) begin
            error_cnt++;
            wrap_up;
        end
        @(posedge aclk);
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (200) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                got = 1'b1;
                break;
            end
        end
        rready <= 1'b0;
        if (!got) begin
            error_cnt++;
            wrap_up;
        end
        @(posedge aclk);
    endtask

    function automatic logic [23:0] mk(input logic [7:0] addr, input logic ack, input logic [8:0] code);
        return {addr, 5'h00, ack, 1'b0, code};
    endfunction

    task run_frame(input logic [23:0] f, input int nbits, input int t_s, input int t_l, input int bad,
                   input logic [8:0] exp_code, input logic exp_ack);
        int acks0;
        acks0 = ack_cnt;
        u_master.send(f, nbits, t_s, t_l, bad);
        repeat (130) @(posedge aclk);
        `CHK(ack_active, exp_ack)
        repeat (nbits == 24 ? 100 : 2400) @(posedge aclk);
        `CHK(brightness_code, exp_code)
        `CHK(ack_cnt - acks0, int'(exp_ack))
        if (exp_ack) `CHK(ack_len, ACK_LOW_C)
        $display("test done: frame %h bits %0d", f, nbits);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(brightness_code, `BRT_DEFAULT)
        `CHK(line_out, 1'b0)
        axi_rd(`REG_BRIGHT, rd, rsp);
        `CHK(rd[8:0], `BRT_DEFAULT)
        axi_rd(8'h0C, rd, rsp);
        `CHK(rsp, `RESP_SLVERR)
        axi_wr(8'h0C, 32'h0000_0001, rsp);
        `CHK(rsp, `RESP_SLVERR)
        $display("test done: reset and map");
        run_frame(mk(`DEV_ADDR, 1'b0, 9'h0A5), 24, 8, 24, -1, 9'h0A5, 1'b0);
        axi_rd(`REG_BRIGHT, rd, rsp);
        `CHK(rd[8:0], 9'h0A5)
        run_frame(mk(`DEV_ADDR, 1'b1, 9'h100), 24, 200, 600, -1, 9'h100, 1'b1);
        run_frame(mk(8'h8E, 1'b1, 9'h055), 24, 8, 24, -1, 9'h100, 1'b0);
        axi_rd(`REG_STATUS, rd, rsp);
        `CHK(rd[`ST_MISS_BIT], 1'b1)
        run_frame(mk(`DEV_ADDR, 1'b1, 9'h055), 24, 8, 24, 5, 9'h100, 1'b0);
        axi_rd(`REG_STATUS, rd, rsp);
        `CHK(rd[`ST_BAD_BIT], 1'b1)
        axi_wr(`REG_STATUS, 32'h0000_0007, rsp);
        `CHK(rsp, `RESP_OKAY)
        axi_rd(`REG_STATUS, rd, rsp);
        `CHK(rd[15:0], 16'h0200)
        run_frame(mk(`DEV_ADDR, 1'b1, 9'h055), 12, 8, 24, -1, 9'h100, 1'b0);
        axi_rd(`REG_STATUS, rd, rsp);
        `CHK(rd[`ST_BAD_BIT], 1'b1)
        axi_wr(`REG_CTRL, 32'h0000_0000, rsp);
        repeat (2) @(posedge aclk);
        `CHK(brightness_code, `BRT_DEFAULT)
        axi_wr(`REG_CTRL, 32'h0000_0001, rsp);
        `CHK(rsp, `RESP_OKAY)
        $display("test done: disable and enable");
        run_frame(mk(`DEV_ADDR, 1'b1, 9'h000), 24, 8, 24, -1, 9'h000, 1'b1);
        wrap_up;
    end

    initial begin
        repeat (100000) @(posedge aclk);
        error_cnt++;
        wrap_up;
    end
endmodule
